// File: hdl/nsc_cfg_ctrl.v
// configuration registers and self-test sequencer of the navigation
// sensor; assumes a simple one-cycle register port on clk, a laser
// fault pin from the laser driver and frame logic on the same clock
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "nsc_cfg_map.vh"

// Operation
// - laser mode 0 keeps laser on; 1 lights it only when frame needs
// - writing test bit 1 runs tests and loads 16-bit result word
// - laser fault during the test forces a failing result
// - test end restores working and firmware memory to defaults
// - test lasts 200ms at 24MHz, fixed count of sensor cycles
// - bits 4 and 2 select 400, 800, 1600 or 2000 cpi
// - extended register at 0x0b resets 0x08, busy bit 7, bits 2..0
// - busy reads 1 while frame and shutter bound writes are blocked
// - gain-loop disable stops gain control, shutter held at maximum
// - fixed frame rate takes period from maximum bound registers
// - passing test reads 0xA9 high, 0xD5 low, either order
module nsc_cfg_ctrl #(
    parameter TEST_CYCLES = `NSC_TEST_TIME_MS * `NSC_TEST_REF_KHZ,
    parameter FAIL_HI     = 8'h00,
    parameter FAIL_LO     = 8'h00
) (
    // clock and reset
    input  wire                     clk,
    input  wire                     arst_n,
    // register port
    input  wire [`NSC_ADDR_W-1:0]   regAddr,
    input  wire [`NSC_DATA_W-1:0]   regWrData,
    input  wire                     regWr,
    input  wire                     regRd,
    output reg  [`NSC_DATA_W-1:0]   regRdData,
    // sensor status
    input  wire                     laserFaultPin,
    input  wire                     fwImageLoaded,
    input  wire                     boundWriteBlocked,
    input  wire                     illumNeeded,
    // sensor control
    output reg                      laserOn,
    output reg  [1:0]               resolutionSel,
    output reg                      serialPullupDisable,
    output reg                      gainLoopDisable,
    output reg                      shutterHoldMax,
    output reg                      fixedFrameRate,
    output reg                      selfTestActive,
    output reg                      memRestore,
    // interrupt
    output reg                      irq
);

    localparam integer TEST_LAST_I = TEST_CYCLES - 1;
    localparam [`NSC_TEST_CNT_W-1:0] TEST_LAST =
        TEST_LAST_I[`NSC_TEST_CNT_W-1:0];
    localparam [`NSC_DATA_W-1:0] MAIN_RST = `NSC_MAIN_RESET;
    localparam [`NSC_DATA_W-1:0] EXT_RST  = `NSC_EXT_RESET;

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    // register match, shared by the read and write decoders
    function hit;
        input [`NSC_ADDR_W-1:0] addr;
        input [`NSC_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    reg                        laserMode_q;
    reg                        laserMode_d;
    reg                        testBit_q;
    reg                        testBit_d;
    reg                        resHi_q;
    reg                        resHi_d;
    reg                        resLo_q;
    reg                        resLo_d;
    reg [1:0]                  mainRsvd_q;
    reg                        pullup_q;
    reg                        pullup_d;
    reg                        gain_q;
    reg                        gain_d;
    reg                        frame_q;
    reg                        frame_d;
    reg [`NSC_DATA_W-1:0]      resultHi_q;
    reg [`NSC_DATA_W-1:0]      resultHi_d;
    reg [`NSC_DATA_W-1:0]      resultLo_q;
    reg [`NSC_DATA_W-1:0]      resultLo_d;
    reg [1:0]                  state_q;
    reg [1:0]                  state_d;
    reg [`NSC_TEST_CNT_W-1:0]  cnt_q;
    reg [`NSC_TEST_CNT_W-1:0]  cnt_d;
    reg                        fail_q;
    reg                        fail_d;
    reg                        busyPrev_q;
    reg [`NSC_IRQ_W-1:0]       irqStatus_q;
    reg [`NSC_IRQ_W-1:0]       irqStatus_d;
    reg [`NSC_IRQ_W-1:0]       irqMask_q;
    reg [`NSC_IRQ_W-1:0]       irqMask_d;
    reg [`NSC_IRQ_W-1:0]       irqEvent;
    reg [`NSC_DATA_W-1:0]      mainView;
    reg [`NSC_DATA_W-1:0]      extView;
    reg [`NSC_DATA_W-1:0]      rdData_d;
    reg                        wrMain;
    reg                        wrExt;
    reg                        wrStatus;
    reg                        wrMask;
    reg                        testStart;
    reg                        testEnd;

    wire                       laserFault;
    wire                       portOpen;

    nsc_sync_2ff #(
        .WIDTH   (1)
    ) uFaultSync (
        .clk     (clk),
        .arst_n  (arst_n),
        .asyncIn (laserFaultPin),
        .syncOut (laserFault)
    );

    // the port is closed while the test runs; accesses are dropped
    // rather than queued since memory is being rewritten anyway
    assign portOpen = (state_q == ST_IDLE);

    // readback views
    always @* begin
        mainView = {`NSC_DATA_W{1'b0}};
        mainView[`NSC_MAIN_FIXED0_BIT] = 1'b0;
        mainView[`NSC_MAIN_LASER_BIT]  = laserMode_q;
        mainView[`NSC_MAIN_TEST_BIT]   = testBit_q;
        mainView[`NSC_MAIN_RESHI_BIT]  = resHi_q;
        mainView[`NSC_MAIN_FIXED1_BIT] = 1'b1;
        mainView[`NSC_MAIN_RESLO_BIT]  = resLo_q;
        mainView[`NSC_MAIN_RSVD_HI]    = mainRsvd_q[1];
        mainView[`NSC_MAIN_RSVD_LO]    = mainRsvd_q[0];
        extView = {`NSC_DATA_W{1'b0}};
        extView[`NSC_EXT_BUSY_BIT]     = boundWriteBlocked;
        extView[`NSC_EXT_FIXED1_BIT]   = 1'b1;
        extView[`NSC_EXT_PULLUP_BIT]   = pullup_q;
        extView[`NSC_EXT_GAIN_BIT]     = gain_q;
        extView[`NSC_EXT_FRAME_BIT]    = frame_q;
    end

    // write decode
    always @* begin
        wrMain   = 1'b0;
        wrExt    = 1'b0;
        wrStatus = 1'b0;
        wrMask   = 1'b0;
        if (regWr && portOpen) begin
            if (hit(regAddr, `NSC_OFF_MAIN_CFG)) begin
                wrMain = 1'b1;
            end else if (hit(regAddr, `NSC_OFF_EXT_CFG)) begin
                wrExt = 1'b1;
            end else if (hit(regAddr, `NSC_OFF_IRQ_STATUS)) begin
                wrStatus = 1'b1;
            end else if (hit(regAddr, `NSC_OFF_IRQ_MASK)) begin
                wrMask = 1'b1;
            end
        end
    end

    // read decode; unmapped addresses read zero
    always @* begin
        rdData_d = {`NSC_DATA_W{1'b0}};
        if (regRd && portOpen) begin
            if (hit(regAddr, `NSC_OFF_MAIN_CFG)) begin
                rdData_d = mainView;
            end else if (hit(regAddr, `NSC_OFF_EXT_CFG)) begin
                rdData_d = extView;
            end else if (hit(regAddr, `NSC_OFF_RESULT_LO)) begin
                rdData_d = resultLo_q;
            end else if (hit(regAddr, `NSC_OFF_RESULT_HI)) begin
                rdData_d = resultHi_q;
            end else if (hit(regAddr, `NSC_OFF_IRQ_STATUS)) begin
                rdData_d = {{(`NSC_DATA_W-`NSC_IRQ_W){1'b0}}, irqStatus_q};
            end else if (hit(regAddr, `NSC_OFF_IRQ_MASK)) begin
                rdData_d = {{(`NSC_DATA_W-`NSC_IRQ_W){1'b0}}, irqMask_q};
            end
        end
    end

    // self-test sequencer
    always @* begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        fail_d    = fail_q;
        testStart = 1'b0;
        testEnd   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // writing zero to the test bit starts nothing
                if (wrMain && regWrData[`NSC_MAIN_TEST_BIT]) begin
                    testStart = 1'b1;
                    state_d   = ST_RUN;
                    cnt_d     = {`NSC_TEST_CNT_W{1'b0}};
                    // a firmware image loaded since reset, by an earlier test, fails the run
                    fail_d    = fwImageLoaded;
                end
            end
            ST_RUN: begin
                if (laserFault) begin
                    fail_d = 1'b1;
                end
                // duration is a fixed cycle count, so it scales with clk
                if (cnt_q == TEST_LAST) begin
                    state_d = ST_DONE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_DONE: begin
                testEnd = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // configuration next state
    always @* begin
        laserMode_d = laserMode_q;
        testBit_d   = testBit_q;
        resHi_d     = resHi_q;
        resLo_d     = resLo_q;
        pullup_d    = pullup_q;
        gain_d      = gain_q;
        frame_d     = frame_q;
        if (wrMain) begin
            // bits 7 and 3 are fixed; the host keeps them at those values
            laserMode_d = regWrData[`NSC_MAIN_LASER_BIT];
            testBit_d   = regWrData[`NSC_MAIN_TEST_BIT];
            resHi_d     = regWrData[`NSC_MAIN_RESHI_BIT];
            resLo_d     = regWrData[`NSC_MAIN_RESLO_BIT];
        end
        if (wrExt) begin
            pullup_d = regWrData[`NSC_EXT_PULLUP_BIT];
            gain_d   = regWrData[`NSC_EXT_GAIN_BIT];
            frame_d  = regWrData[`NSC_EXT_FRAME_BIT];
        end
        // the memory check wipes settings, so all return to reset values
        if (testEnd) begin
            laserMode_d = MAIN_RST[`NSC_MAIN_LASER_BIT];
            testBit_d   = MAIN_RST[`NSC_MAIN_TEST_BIT];
            resHi_d     = MAIN_RST[`NSC_MAIN_RESHI_BIT];
            resLo_d     = MAIN_RST[`NSC_MAIN_RESLO_BIT];
            pullup_d    = EXT_RST[`NSC_EXT_PULLUP_BIT];
            gain_d      = EXT_RST[`NSC_EXT_GAIN_BIT];
            frame_d     = EXT_RST[`NSC_EXT_FRAME_BIT];
        end
    end

    // result word
    always @* begin
        resultHi_d = resultHi_q;
        resultLo_d = resultLo_q;
        if (testEnd) begin
            if (fail_q) begin
                resultHi_d = FAIL_HI;
                resultLo_d = FAIL_LO;
            end else begin
                resultHi_d = `NSC_PASS_HI;
                resultLo_d = `NSC_PASS_LO;
            end
        end
    end

    // interrupt status: a set in the clearing cycle wins
    always @* begin
        irqEvent = {`NSC_IRQ_W{1'b0}};
        irqEvent[`NSC_IRQ_DONE_BIT] = testEnd;
        irqEvent[`NSC_IRQ_FAIL_BIT] = testEnd && fail_q;
        irqEvent[`NSC_IRQ_FREE_BIT] = busyPrev_q && !boundWriteBlocked;
        irqStatus_d = irqStatus_q;
        if (wrStatus) begin
            irqStatus_d = irqStatus_q & ~regWrData[`NSC_IRQ_W-1:0];
        end
        irqStatus_d = irqStatus_d | irqEvent;
        irqMask_d = irqMask_q;
        if (wrMask) begin
            irqMask_d = regWrData[`NSC_IRQ_W-1:0];
        end
    end

    // state registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            laserMode_q <= MAIN_RST[`NSC_MAIN_LASER_BIT];
            testBit_q   <= MAIN_RST[`NSC_MAIN_TEST_BIT];
            resHi_q     <= MAIN_RST[`NSC_MAIN_RESHI_BIT];
            resLo_q     <= MAIN_RST[`NSC_MAIN_RESLO_BIT];
            mainRsvd_q  <= MAIN_RST[`NSC_MAIN_RSVD_HI:`NSC_MAIN_RSVD_LO];
            pullup_q    <= EXT_RST[`NSC_EXT_PULLUP_BIT];
            gain_q      <= EXT_RST[`NSC_EXT_GAIN_BIT];
            frame_q     <= EXT_RST[`NSC_EXT_FRAME_BIT];
            resultHi_q  <= `NSC_RESULT_RESET;
            resultLo_q  <= `NSC_RESULT_RESET;
            state_q     <= ST_IDLE;
            cnt_q       <= {`NSC_TEST_CNT_W{1'b0}};
            fail_q      <= 1'b0;
            busyPrev_q  <= 1'b0;
            irqStatus_q <= `NSC_IRQ_RESET;
            irqMask_q   <= `NSC_IRQ_RESET;
        end else begin
            laserMode_q <= laserMode_d;
            testBit_q   <= testBit_d;
            resHi_q     <= resHi_d;
            resLo_q     <= resLo_d;
            mainRsvd_q  <= mainRsvd_q;
            pullup_q    <= pullup_d;
            gain_q      <= gain_d;
            frame_q     <= frame_d;
            resultHi_q  <= resultHi_d;
            resultLo_q  <= resultLo_d;
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            fail_q      <= fail_d;
            busyPrev_q  <= boundWriteBlocked;
            irqStatus_q <= irqStatus_d;
            irqMask_q   <= irqMask_d;
        end
    end

    // registered outputs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData           <= {`NSC_DATA_W{1'b0}};
            laserOn             <= 1'b0;
            resolutionSel       <= `NSC_RES_400;
            serialPullupDisable <= 1'b0;
            gainLoopDisable     <= 1'b0;
            shutterHoldMax      <= 1'b0;
            fixedFrameRate      <= 1'b0;
            selfTestActive      <= 1'b0;
            memRestore          <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            regRdData           <= rdData_d;
            // gated mode trades a cycle of latency for laser lifetime
            laserOn             <= !laserMode_d || illumNeeded;
            resolutionSel       <= {resHi_d, resLo_d};
            serialPullupDisable <= pullup_d;
            gainLoopDisable     <= gain_d;
            shutterHoldMax      <= gain_d;
            fixedFrameRate      <= frame_d;
            selfTestActive      <= (state_d != ST_IDLE);
            // memory owners reload defaults on this pulse
            memRestore          <= testEnd;
            irq                 <= |(irqStatus_d & irqMask_d);
        end
    end

endmodule

`default_nettype wire

// File: hdl/nsc_cfg_map.vh
// register map, field positions, reset values and timing figures
// of the navigation sensor configuration block
// assumes an 8-bit register port with byte addresses
`ifndef NSC_CFG_MAP_VH
`define NSC_CFG_MAP_VH

// register offsets
`define NSC_ADDR_W            8
`define NSC_DATA_W            8
`define NSC_OFF_MAIN_CFG      8'h0A
`define NSC_OFF_EXT_CFG       8'h0B
`define NSC_OFF_RESULT_LO     8'h0C
`define NSC_OFF_RESULT_HI     8'h0D
`define NSC_OFF_IRQ_STATUS    8'h30
`define NSC_OFF_IRQ_MASK      8'h31

// main configuration fields
`define NSC_MAIN_FIXED0_BIT   7
`define NSC_MAIN_LASER_BIT    6
`define NSC_MAIN_TEST_BIT     5
`define NSC_MAIN_RESHI_BIT    4
`define NSC_MAIN_FIXED1_BIT   3
`define NSC_MAIN_RESLO_BIT    2
`define NSC_MAIN_RSVD_HI      1
`define NSC_MAIN_RSVD_LO      0
`define NSC_MAIN_RESET        8'h49

// extended configuration fields
`define NSC_EXT_BUSY_BIT      7
`define NSC_EXT_FIXED1_BIT    3
`define NSC_EXT_PULLUP_BIT    2
`define NSC_EXT_GAIN_BIT      1
`define NSC_EXT_FRAME_BIT     0
`define NSC_EXT_RESET         8'h08

// resolution codes {high select, low select}
`define NSC_RES_400           2'h0
`define NSC_RES_800           2'h2
`define NSC_RES_1600          2'h1
`define NSC_RES_2000          2'h3

// self-test result words
`define NSC_PASS_HI           8'hA9
`define NSC_PASS_LO           8'hD5
`define NSC_RESULT_RESET      8'h00

// interrupt status bits
`define NSC_IRQ_W             3
`define NSC_IRQ_DONE_BIT      0
`define NSC_IRQ_FAIL_BIT      1
`define NSC_IRQ_FREE_BIT      2
`define NSC_IRQ_RESET         3'h0

// self-test duration, counted in sensor clock cycles
`define NSC_TEST_TIME_MS      200
`define NSC_TEST_REF_KHZ      24000
`define NSC_TEST_CNT_W        23

`endif

// File: hdl/nsc_sync_2ff.v
// two-stage synchroniser for levels entering the sensor clock domain
// assumes inputs are quasi-static relative to clk
`timescale 1ns/100ps
`default_nettype none

module nsc_sync_2ff #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             arst_n,
    // asynchronous in, synchronous out
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;

    // stage1 is read by stage2 only
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;

endmodule

`default_nettype wire

// File: dv/nsc_cfg_ctrl_chk.sv
// assertions on the ports of the configuration block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module nsc_cfg_ctrl_chk #(
    parameter TEST_CYCLES = 20
) (
    // clock and reset
    input wire       clk,
    input wire       arst_n,
    // register port
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWr,
    input wire       regRd,
    input wire [7:0] regRdData,
    // sensor status
    input wire       laserFaultPin,
    input wire       fwImageLoaded,
    input wire       boundWriteBlocked,
    input wire       illumNeeded,
    // sensor control
    input wire       laserOn,
    input wire [1:0] resolutionSel,
    input wire       serialPullupDisable,
    input wire       gainLoopDisable,
    input wire       shutterHoldMax,
    input wire       fixedFrameRate,
    input wire       selfTestActive,
    input wire       memRestore,
    input wire       irq
);
    // length of the current test run, in clk cycles
    logic [31:0] runCnt_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            runCnt_q <= 32'h0;
        end else begin
            runCnt_q <= selfTestActive ? runCnt_q + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_laser_follow: assert property (
        $past(arst_n) && $past(illumNeeded) |-> laserOn)
        else $error("laser dark while a frame needs light");
    chk_res_write: assert property (
        regWr && regAddr == 8'h0A && !selfTestActive |=>
        resolutionSel == {$past(regWrData[4]), $past(regWrData[2])})
        else $error("resolution select differs from written bits");
    chk_ext_write: assert property (
        regWr && regAddr == 8'h0B && !selfTestActive |=>
        {serialPullupDisable, gainLoopDisable, fixedFrameRate}
        == $past(regWrData[2:0]))
        else $error("extended controls differ from written bits");
    chk_shutter_hold: assert property (
        shutterHoldMax == gainLoopDisable)
        else $error("shutter hold differs from gain loop disable");
    chk_test_length: assert property (
        $fell(selfTestActive) |-> runCnt_q == TEST_CYCLES + 1)
        else $error("self-test run length wrong");
    chk_test_restore: assert property (
        $fell(selfTestActive) |-> resolutionSel == 2'h0 &&
        !gainLoopDisable && !fixedFrameRate && !serialPullupDisable)
        else $error("configuration not restored at test end");
    chk_restore_pulse: assert property (
        memRestore |-> $fell(selfTestActive) ##1 !memRestore)
        else $error("memory restore pulse misplaced");
    chk_busy_read: assert property (
        regRd && regAddr == 8'h0B && !selfTestActive |=>
        regRdData[7] == $past(boundWriteBlocked) && regRdData[3])
        else $error("busy or fixed bit wrong in extended read");
    chk_main_fixed: assert property (
        regRd && regAddr == 8'h0A && !selfTestActive |=>
        !regRdData[7] && regRdData[3])
        else $error("fixed bits wrong in main configuration read");
endmodule

bind nsc_cfg_ctrl nsc_cfg_ctrl_chk #(.TEST_CYCLES(TEST_CYCLES)) u_chk (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .laserFaultPin(laserFaultPin),
    .fwImageLoaded(fwImageLoaded), .boundWriteBlocked(boundWriteBlocked),
    .illumNeeded(illumNeeded), .laserOn(laserOn),
    .resolutionSel(resolutionSel),
    .serialPullupDisable(serialPullupDisable),
    .gainLoopDisable(gainLoopDisable), .shutterHoldMax(shutterHoldMax),
    .fixedFrameRate(fixedFrameRate), .selfTestActive(selfTestActive),
    .memRestore(memRestore), .irq(irq)
);

`default_nettype wire

// File: dv/nsc_host_model.sv
// host microcontroller model on the register port
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none

module nsc_host_model (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // register port
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic       regWr,
    output logic       regRd,
    input  wire  [7:0] regRdData,
    // sensor state seen by the host
    input  wire        selfTestActive,
    input  wire        memRestore,
    output logic       fwImageLoaded
);
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // a hard reset empties the image; it is reloaded once a test ends
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwImageLoaded <= 1'b0;
        end else if (memRestore) begin
            fwImageLoaded <= 1'b1;
        end
    end

    // port stays idle while a test runs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wait (!selfTestActive);
        @(posedge clk);
        regAddr <= a;
        regWrData <= (a == 8'h0A) ? ((d & 8'h7F) | 8'h08) : d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        wait (!selfTestActive);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask
endmodule

`default_nettype wire

// File: dv/nsc_cfg_ctrl_test.sv
// self-checking bench for the configuration block
// assumes the host model owns the register port
`timescale 1ns/100ps
`default_nettype none

module nsc_cfg_ctrl_test;
    // short test so the run stays brief
    localparam int TC = 20;
    localparam logic [7:0] FAIL_HI = 8'h00;
    localparam logic [7:0] FAIL_LO = 8'h00;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       laserFaultPin = 1'b0;
    logic       boundWriteBlocked = 1'b0;
    logic       illumNeeded = 1'b0;
    wire  [7:0] regAddr, regWrData, regRdData;
    wire        regWr, regRd, fwImageLoaded, laserOn, irq;
    wire        serialPullupDisable, gainLoopDisable, shutterHoldMax;
    wire        fixedFrameRate, selfTestActive, memRestore;
    wire  [1:0] resolutionSel;
    int         nMismatch = 0;
    int         comparisons = 0;
    int         cyc;
    logic [7:0] rdv;

    always #5 clk = ~clk;

    nsc_host_model host (
        .clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .selfTestActive(selfTestActive),
        .memRestore(memRestore), .fwImageLoaded(fwImageLoaded)
    );

    nsc_cfg_ctrl #(
        .TEST_CYCLES(TC), .FAIL_HI(FAIL_HI), .FAIL_LO(FAIL_LO)
    ) dut (
        .clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .laserFaultPin(laserFaultPin),
        .fwImageLoaded(fwImageLoaded),
        .boundWriteBlocked(boundWriteBlocked), .illumNeeded(illumNeeded),
        .laserOn(laserOn), .resolutionSel(resolutionSel),
        .serialPullupDisable(serialPullupDisable),
        .gainLoopDisable(gainLoopDisable), .shutterHoldMax(shutterHoldMax),
        .fixedFrameRate(fixedFrameRate), .selfTestActive(selfTestActive),
        .memRestore(memRestore), .irq(irq)
    );

    task automatic check(input string what, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, exp);
        host.rd(a, rdv);
        check($sformatf("reg %h", a), rdv, exp);
    endtask

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic hwReset;
        @(posedge clk) arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
    endtask

    // runs one self-test and checks length, results and status
    task automatic runTest(input logic [7:0] hi, lo, input logic [2:0] st);
        host.wr(8'h0A, 8'h69);
        cyc = 0;
        @(negedge clk);
        while (selfTestActive && cyc < 1000) begin
            cyc++;
            @(negedge clk);
        end
        check("test length", cyc[7:0], 8'(TC + 1));
        check("restore", {7'h0, memRestore}, 8'h01);
        rdChk(8'h0D, hi);
        rdChk(8'h0C, lo);
        rdChk(8'h0D, hi);
        rdChk(8'h0A, 8'h49);
        rdChk(8'h0B, 8'h08);
        rdChk(8'h30, {5'h0, st});
        host.wr(8'h30, 8'h07);
    endtask

    initial begin
        hwReset();
        rdChk(8'h0A, 8'h49);
        rdChk(8'h0B, 8'h08);
        @(posedge clk) boundWriteBlocked <= 1'b1;
        rdChk(8'h0B, 8'h88);
        host.wr(8'h20, 8'h55);
        rdChk(8'h20, 8'h00);
        // free event raised, cleared, then masked
        host.wr(8'h31, 8'h04);
        @(posedge clk) boundWriteBlocked <= 1'b0;
        rdChk(8'h30, 8'h04);
        check("irq", {7'h0, irq}, 8'h01);
        host.wr(8'h30, 8'h04);
        @(negedge clk);
        check("irq", {7'h0, irq}, 8'h00);
        host.wr(8'h31, 8'h00);
        @(posedge clk) boundWriteBlocked <= 1'b1;
        @(posedge clk) boundWriteBlocked <= 1'b0;
        rdChk(8'h30, 8'h04);
        check("irq", {7'h0, irq}, 8'h00);
        host.wr(8'h31, 8'h04);
        @(negedge clk);
        check("irq", {7'h0, irq}, 8'h01);
        host.wr(8'h30, 8'h04);
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h0A, {3'h2, i[1], 1'h1, i[0], 2'h1});
            @(negedge clk);
            check("res", {6'h0, resolutionSel}, 8'(i));
            check("idle", {7'h0, selfTestActive}, 8'h00);
            rdChk(8'h0A, {3'h2, i[1], 1'h1, i[0], 2'h1});
        end
        check("laser", {7'h0, laserOn}, 8'h00);
        @(posedge clk) illumNeeded <= 1'b1;
        repeat (2) @(negedge clk);
        check("laser", {7'h0, laserOn}, 8'h01);
        @(posedge clk) illumNeeded <= 1'b0;
        host.wr(8'h0A, 8'h09);
        repeat (2) @(negedge clk);
        check("laser", {7'h0, laserOn}, 8'h01);
        host.wr(8'h0B, 8'hFF);
        @(negedge clk);
        check("ext", {4'h0, serialPullupDisable, gainLoopDisable,
            fixedFrameRate, shutterHoldMax}, 8'h0F);
        rdChk(8'h0B, 8'h0F);
        // stale settings must be wiped by the test
        hwReset();
        host.wr(8'h0B, 8'h07);
        runTest(8'hA9, 8'hD5, 3'h1);
        runTest(FAIL_HI, FAIL_LO, 3'h3);
        hwReset();
        fork
            runTest(FAIL_HI, FAIL_LO, 3'h3);
            begin
                repeat (8) @(posedge clk);
                laserFaultPin <= 1'b1;
                repeat (4) @(posedge clk);
                laserFaultPin <= 1'b0;
            end
        join
        host.wr(8'h0A, 8'h59);
        rdChk(8'h0A, 8'h59);
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk);
        nMismatch++;
        stop_test();
    end
endmodule

`default_nettype wire
